// ### design/cpu_ctl_map.vh
// Purpose: constants for the skip, operate and in-out transfer control block
// Assumes: 36-bit words, octal-coded address fields, 50 MHz core clock
// Notes: included by the control module and the test bench
// What this block does
// - Plus accumulator test skips when sign zero
// - Minus accumulator test skips when sign one
// - Zero overflow test skips, clears overflow unless an overflow edge lands in that cycle
// - Overflow sticky from arithmetic, cleared by start
// - Plus in-out test skips when sign zero
// - Sense switch selects one to six, seventy all
// - Flag field selects none, one flag, all
// - Combined skip tests OR together, same time
// - Operate bit clears whole in-out register
// - Test word switches ORed into accumulator
// - Complement bit inverts every accumulator bit
// - Halt bit stops until console restart
// - Clear bit zeroes the accumulator
// - Low digit one to seven clears flags
// - Values eleven to seventeen set flags
// - Wait bit suspends until device completion pulse
// - No wait bit starts device and continues
// - Address one to seven selects device function
// - Start fetches from test address switches
// - Stop halts after cycle, continue resumes
// - Examine reads memory, deposit writes test word
// - Single cycle halts after every memory cycle
// - Skip group uses no memory, address selects
`ifndef CPU_CTL_MAP_VH
`define CPU_CTL_MAP_VH
`define OP_SKIP 6'h0034
`define OP_OPER 6'h003E
`define OP_IOT 6'h003A
`define SK_PLUS_AC 12'h0080
`define SK_MINUS_AC 12'h0100
`define SK_ZERO_OV 12'h0200
`define SK_PLUS_IO 12'h0400
`define OPR_CLI 12'h0800
`define OPR_LAT 12'h0400
`define OPR_CMA 12'h0200
`define OPR_HLT 12'h0100
`define OPR_CLA 12'h0080
`define OPR_SETF 12'h0008
`define FLAG_ALL 3'h7
`define FLAG_NONE 3'h0
`define SIGN_BIT 35
`define WORD_ZERO 36'h0_0000_0000
`define IOT_WAIT_BIT 12
`define ST_IDLE 3'h0
`define ST_FETCH 3'h1
`define ST_EXEC 3'h2
`define ST_IOWAIT 3'h3
`define ST_MEMRD 3'h4
`define ST_MEMWR 3'h5
`endif

// ### design/cpu_ctl.v
// Purpose: skip, operate and in-out transfer control with console sequencing
// Assumes: instruction word = 6-bit opcode, bit 12 wait/indirect, 12-bit address
// Notes: memory, arithmetic and devices sit outside; all console inputs are pins
`default_nettype none
`include "cpu_ctl_map.vh"
module cpu_ctl (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [35:0] mem_rdata_i,
    input wire mem_done_i,
    input wire arith_ovf_i,
    input wire io_done_i,
    input wire start_i,
    input wire stop_i,
    input wire cont_i,
    input wire examine_i,
    input wire deposit_i,
    input wire single_cyc_i,
    input wire [14:0] test_addr_i,
    input wire [35:0] test_word_i,
    input wire [5:0] sense_sw_i,
    input wire [5:0] flag_set_i,
    output reg [14:0] mem_addr_o,
    output reg [35:0] mem_wdata_o,
    output reg mem_rd_o,
    output reg mem_wr_o,
    output reg [14:0] pc_o,
    output reg [35:0] ac_o,
    output reg [35:0] io_o,
    output reg [35:0] mb_o,
    output reg ovf_o,
    output reg [5:0] flags_o,
    output reg run_o,
    output reg [2:0] dev_func_o,
    output reg dev_start_o
);
    // Overview of the sequencer
    // IDLE waits for a console button. Start, continue, examine and deposit
    // are refused while the machine runs; stop is taken at any time.
    // FETCH waits for the memory to report done, then latches the word into
    // the instruction register and the memory buffer and steps the counter.
    // EXEC applies the whole instruction in one cycle and issues the next read unless it halts, stops or parks.
    // IOWAIT parks the machine until the selected device reports completion.
    // MEMRD and MEMWR serve the examine and deposit buttons.
    //
    // Only three opcode groups are decoded here. Every other opcode passes
    // through EXEC as a no-op, since memory-reference, shift and rotate
    // instructions belong to the arithmetic section outside this block.
    //
    // Timing hazards
    // Every console button, switch bank and memory line arrives from another
    // timing world, so each passes two flops before logic reads it. Buttons
    // then add a third flop for edge detection, which holds the previous value and adds no delay,
    // so a press takes the same two cycles as any other pin before the sequencer acts on it.
    // The memory word is delayed through the same two stages as its done
    // flag, so the data and the flag reach the sequencer in the same cycle.
    // Sampling the raw data beside the synced flag would read a stale word
    // once the memory has already dropped done.
    // The switch banks are delayed the same way; an operator who sets the
    // switches and presses a button at once still sees the new setting used,
    // because the button edge reaches the sequencer in the same cycle as the settled switches.
    //
    // The sign tests look at bit 35 only, so a negative zero in the
    // accumulator counts as minus, as ones-complement hardware does.
    //
    // Program flags can be raised by devices at any time through flag_set_i.
    // A device set and a program clear in the same cycle leave the flag set,
    // so a key strike is never lost to a clear that happens to coincide.
    //
    // Overflow follows the same policy: an arithmetic overflow edge that
    // lands in the cycle of a zero-overflow skip leaves the flag set.
    //
    // Limitations: a continue with no earlier start fetches from address
    // zero, and the single-cycle switch stops after each instruction, as
    // every instruction handled here takes one memory cycle.
    // Two-stage synchronisers for every asynchronous pin
    reg [8:0] pin_s1_reg;
    reg [8:0] pin_s2_reg;
    reg [8:0] pin_d_reg; // Previous synced value, for edge detect
    reg [5:0] sw_s1_reg;
    reg [5:0] sw_s2_reg;
    reg [5:0] fl_s1_reg;
    reg [5:0] fl_s2_reg;
    reg [2:0] state_reg; // Sequencer state
    reg [35:0] ir_reg; // Instruction being executed
    reg stop_pend_reg; // Stop requested, honoured at cycle end
    // Settled copies of the switch banks and of the memory word
    reg [14:0] taddr_s1_reg; // Test address, first stage
    reg [14:0] taddr_s2_reg; // Test address, read by the sequencer
    reg [35:0] tword_s1_reg; // Test word, first stage
    reg [35:0] tword_s2_reg; // Test word, read by deposit and load
    reg [35:0] rdata_s1_reg; // Memory word, first stage
    reg [35:0] rdata_s2_reg; // Memory word, aligned with the synced done
    // Pin bundle order: bit 0 is memory done, bit 8 is device completion
    wire [8:0] pin_now = {io_done_i, arith_ovf_i, single_cyc_i, deposit_i,
                          examine_i, cont_i, stop_i, start_i, mem_done_i};
    wire mem_done = pin_s2_reg[0];
    wire start_p = pin_s2_reg[1] & ~pin_d_reg[1];
    wire stop_p = pin_s2_reg[2] & ~pin_d_reg[2];
    wire cont_p = pin_s2_reg[3] & ~pin_d_reg[3];
    wire exam_p = pin_s2_reg[4] & ~pin_d_reg[4];
    wire dep_p = pin_s2_reg[5] & ~pin_d_reg[5];
    wire single_cyc = pin_s2_reg[6];
    wire ovf_p = pin_s2_reg[7] & ~pin_d_reg[7];
    wire io_done_p = pin_s2_reg[8] & ~pin_d_reg[8];
    // Instruction fields; bit 12 is the in-out wait bit for transfers
    wire [5:0] opcode = ir_reg[35:30];
    wire [11:0] addr = ir_reg[11:0];
    wire [2:0] sw_sel = addr[5:3];
    wire [2:0] fl_sel = addr[2:0];
    // Skip condition terms
    reg sw_zero;
    reg fl_zero;
    reg skip_hit;
    reg [5:0] flag_mask;
    // Sense switch and flag selections, seven meaning all
    always @* begin
        if (sw_sel == `FLAG_ALL) begin
            sw_zero = (sw_s2_reg == 6'h00);
        end else if (sw_sel == `FLAG_NONE) begin
            sw_zero = 1'b0;
        end else begin
            sw_zero = ~sw_s2_reg[sw_sel - 3'h1];
        end
        if (fl_sel == `FLAG_ALL) begin
            fl_zero = (flags_o == 6'h00);
            flag_mask = 6'h3F;
        end else if (fl_sel == `FLAG_NONE) begin
            fl_zero = 1'b0;
            flag_mask = 6'h00;
        end else begin
            fl_zero = ~flags_o[fl_sel - 3'h1];
            flag_mask = 6'h01 << (fl_sel - 3'h1);
        end
        // Inclusive OR of every selected test; no memory involved.
        // All terms are evaluated in parallel, so a combined address costs
        // no more time than a single test.
        // Switch and flag selections share the address with the sign tests,
        // so one instruction may test a switch, a flag and a sign together.
        skip_hit = ((addr & `SK_PLUS_AC) != 12'h000 && !ac_o[`SIGN_BIT])
            || ((addr & `SK_MINUS_AC) != 12'h000 && ac_o[`SIGN_BIT])
            || ((addr & `SK_ZERO_OV) != 12'h000 && !ovf_o)
            || ((addr & `SK_PLUS_IO) != 12'h000 && !io_o[`SIGN_BIT])
            || sw_zero || fl_zero;
    end
    // Operate group: clear first, then OR test word, then complement
    reg [35:0] ac_opr;
    always @* begin
        ac_opr = ac_o;
        if ((addr & `OPR_CLA) != 12'h000) begin
            ac_opr = `WORD_ZERO;
        end
        if ((addr & `OPR_LAT) != 12'h000) begin
            // Settled switches, so a bank changing mid-cycle is never mixed
            ac_opr = ac_opr | tword_s2_reg;
        end
        if ((addr & `OPR_CMA) != 12'h000) begin
            ac_opr = ~ac_opr;
        end
    end
    // Main sequencer; test switches are read through their two-stage copies
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pin_s1_reg <= 9'h000;
            pin_s2_reg <= 9'h000;
            pin_d_reg <= 9'h000;
            sw_s1_reg <= 6'h00;
            sw_s2_reg <= 6'h00;
            fl_s1_reg <= 6'h00;
            fl_s2_reg <= 6'h00;
            // Switch and data copies start at zero
            taddr_s1_reg <= 15'h0000;
            taddr_s2_reg <= 15'h0000;
            tword_s1_reg <= `WORD_ZERO;
            tword_s2_reg <= `WORD_ZERO;
            rdata_s1_reg <= `WORD_ZERO;
            rdata_s2_reg <= `WORD_ZERO;
            state_reg <= `ST_IDLE;
            ir_reg <= `WORD_ZERO;
            stop_pend_reg <= 1'b0;
            mem_addr_o <= 15'h0000;
            mem_wdata_o <= `WORD_ZERO;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            pc_o <= 15'h0000;
            ac_o <= `WORD_ZERO;
            io_o <= `WORD_ZERO;
            mb_o <= `WORD_ZERO;
            ovf_o <= 1'b0;
            flags_o <= 6'h00;
            run_o <= 1'b0;
            dev_func_o <= 3'h0;
            dev_start_o <= 1'b0;
        end else begin
            pin_s1_reg <= pin_now;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
            sw_s1_reg <= sense_sw_i;
            sw_s2_reg <= sw_s1_reg;
            fl_s1_reg <= flag_set_i;
            fl_s2_reg <= fl_s1_reg;
            // Switch banks and memory word take the same two-stage path
            taddr_s1_reg <= test_addr_i;
            taddr_s2_reg <= taddr_s1_reg;
            tword_s1_reg <= test_word_i;
            tword_s2_reg <= tword_s1_reg;
            rdata_s1_reg <= mem_rdata_i;
            rdata_s2_reg <= rdata_s1_reg;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            dev_start_o <= 1'b0;
            // Device-raised flags, e.g. a typewriter key strike
            flags_o <= flags_o | fl_s2_reg;
            if (ovf_p) begin
                ovf_o <= 1'b1;
            end
            if (stop_p) begin
                stop_pend_reg <= 1'b1;
            end
            case (state_reg)
                `ST_IDLE: begin
                    // Start: fresh run from the test address switches
                    if (start_p) begin
                        pc_o <= taddr_s2_reg;
                        ovf_o <= 1'b0;
                        stop_pend_reg <= 1'b0;
                        run_o <= 1'b1;
                        mem_addr_o <= taddr_s2_reg;
                        mem_rd_o <= 1'b1;
                        state_reg <= `ST_FETCH;
                    // Continue: resume at the held counter, stop forgotten
                    end else if (cont_p) begin
                        stop_pend_reg <= 1'b0;
                        run_o <= 1'b1;
                        mem_addr_o <= pc_o;
                        mem_rd_o <= 1'b1;
                        state_reg <= `ST_FETCH;
                    // Examine: one read, machine stays stopped
                    end else if (exam_p) begin
                        mem_addr_o <= taddr_s2_reg;
                        mem_rd_o <= 1'b1;
                        state_reg <= `ST_MEMRD;
                    // Deposit: one write of the test word switches
                    end else if (dep_p) begin
                        mem_addr_o <= taddr_s2_reg;
                        mem_wdata_o <= tword_s2_reg;
                        mem_wr_o <= 1'b1;
                        state_reg <= `ST_MEMWR;
                    end
                end
                `ST_FETCH: begin
                    // Data copy is aligned with the synced done flag
                    if (mem_done) begin
                        ir_reg <= rdata_s2_reg;
                        mb_o <= rdata_s2_reg;
                        pc_o <= pc_o + 15'h0001;
                        state_reg <= `ST_EXEC;
                    end
                end
                `ST_EXEC: begin
                    // Default is straight on to the next fetch
                    state_reg <= `ST_FETCH;
                    // Skip group: only the counter and overflow change
                    if (opcode == `OP_SKIP) begin
                        if (skip_hit) begin
                            pc_o <= pc_o + 15'h0001;
                        end
                        if ((addr & `SK_ZERO_OV) != 12'h000) begin
                            ovf_o <= ovf_p;
                        end
                    // Operate group: the upper address bits act independently; the low four set or clear flags
                    end else if (opcode == `OP_OPER) begin
                        ac_o <= ac_opr;
                        if ((addr & `OPR_CLI) != 12'h000) begin
                            io_o <= `WORD_ZERO;
                        end
                        if ((addr & `OPR_SETF) != 12'h000) begin
                            flags_o <= flags_o | fl_s2_reg | flag_mask;
                        end else begin
                            flags_o <= (flags_o & ~flag_mask) | fl_s2_reg;
                        end
                        if ((addr & `OPR_HLT) != 12'h000) begin
                            state_reg <= `ST_IDLE;
                        end
                    // In-out transfer: start the device, optionally park
                    end else if (opcode == `OP_IOT) begin
                        dev_func_o <= addr[2:0];
                        dev_start_o <= (addr[2:0] != `FLAG_NONE);
                        if (ir_reg[`IOT_WAIT_BIT]) begin
                            state_reg <= `ST_IOWAIT;
                        end
                    end
                    // Halt after this cycle on stop or in single-cycle mode
                    if (stop_pend_reg || stop_p || single_cyc) begin
                        state_reg <= `ST_IDLE;
                    end
                    // Next address is the counter, bumped once more on a skip
                    if (state_reg == `ST_EXEC) begin
                        mem_addr_o <= pc_o;
                    end
                    if (!(stop_pend_reg || stop_p || single_cyc) &&
                        !(opcode == `OP_OPER && (addr & `OPR_HLT) != 12'h000) &&
                        !(opcode == `OP_IOT && ir_reg[`IOT_WAIT_BIT])) begin
                        mem_rd_o <= 1'b1;
                        if (opcode == `OP_SKIP && skip_hit) begin
                            mem_addr_o <= pc_o + 15'h0001;
                        end
                    // Parked: run stays lit only while waiting on a device
                    end else begin
                        run_o <= (opcode == `OP_IOT) && ir_reg[`IOT_WAIT_BIT] &&
                                 !(stop_pend_reg || stop_p || single_cyc);
                    end
                end
                `ST_IOWAIT: begin
                    // Timing restarts from the completion pulse itself
                    if (io_done_p) begin
                        mem_addr_o <= pc_o;
                        mem_rd_o <= 1'b1;
                        state_reg <= `ST_FETCH;
                    end
                end
                `ST_MEMRD: begin
                    // Examined word shows in accumulator and buffer
                    if (mem_done) begin
                        ac_o <= rdata_s2_reg;
                        mb_o <= rdata_s2_reg;
                        state_reg <= `ST_IDLE;
                    end
                end
                `ST_MEMWR: begin
                    // Deposited word is echoed in the buffer
                    if (mem_done) begin
                        mb_o <= mem_wdata_o;
                        state_reg <= `ST_IDLE;
                    end
                end
                default: begin
                    // Unused codes fall back to a safe stop
                    state_reg <= `ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verif/cpu_ctl_monitor.sv
// Purpose: port-level checker for the skip, operate and in-out control block
// Assumes: one clock, synchronous active-low reset, console inputs synced inside
// Notes: bound to every instance of the control block
`default_nettype none
module cpu_ctl_monitor (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic arith_ovf_i,
    input wire logic [14:0] test_addr_i,
    input wire logic [14:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic ovf_o,
    input wire logic run_o,
    input wire logic [2:0] dev_func_o,
    input wire logic dev_start_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Start pressed while idle
    sequence s_start_edge;
        $rose(start_i) && !run_o;
    endsequence
    // First fetch comes from the switch address
    sequence s_first_fetch;
        mem_rd_o && run_o && mem_addr_o == test_addr_i;
    endsequence
    property p_start_fetch;
        s_start_edge |-> ##[1:8] s_first_fetch;
    endproperty
    property p_ovf_set;
        $rose(arith_ovf_i) |-> ##[1:6] ovf_o;
    endproperty
    // Overflow only drops around a running cycle, never while parked
    property p_ovf_hold;
        $fell(ovf_o) |-> ##[0:1] run_o;
    endproperty
    property p_rd_pulse;
        mem_rd_o |=> !mem_rd_o;
    endproperty
    // Deposit is the only writer, so writes happen while stopped
    property p_wr_pulse;
        mem_wr_o |-> !run_o ##1 !mem_wr_o;
    endproperty
    property p_excl;
        !(mem_rd_o && mem_wr_o);
    endproperty
    property p_dev_func;
        dev_start_o |-> dev_func_o != 3'h0 ##1 !dev_start_o;
    endproperty
    property p_dev_run;
        dev_start_o |-> run_o;
    endproperty
    property p_run_fetch;
        $rose(run_o) |-> mem_rd_o;
    endproperty
    a_start_fetch: assert property (p_start_fetch) else $error("start did not fetch from switch address");
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not recorded");
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped while stopped");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    a_wr_pulse: assert property (p_wr_pulse) else $error("bad write strobe");
    a_excl: assert property (p_excl) else $error("read and write together");
    a_dev_func: assert property (p_dev_func) else $error("device start without function");
    a_dev_run: assert property (p_dev_run) else $error("device start while stopped");
    a_run_fetch: assert property (p_run_fetch) else $error("resume without fetch");
endmodule
bind cpu_ctl cpu_ctl_monitor u_mon (.*);
`default_nettype wire

// ### verif/mem_dev_model.sv
// Purpose: core memory and one in-out device facing the control block
// Assumes: one memory access at a time
// Notes: latency alternates short and long; data inverted outside done
`default_nettype none
module mem_dev_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [14:0] mem_addr_i,
    input wire logic [35:0] mem_wdata_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic dev_start_i,
    output logic [35:0] mem_rdata_o,
    output logic mem_done_o,
    output logic io_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [0:32767]; // Core store
    logic [14:0] addr_q = '0; // Address of the access in flight
    int lat = 2; // Cycles to done
    int mcnt = 0;
    int dcnt = 0;
    // Done comes lat cycles after a strobe, held two cycles, then low
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mcnt <= 0;
            dcnt <= 0;
        end else begin
            if (mem_rd_i || mem_wr_i) begin
                mcnt <= 1;
                addr_q <= mem_addr_i;
                lat <= 11 - lat;
                if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
            end else if (mcnt != 0) mcnt <= (mcnt == lat + 2) ? 0 : mcnt + 1;
            if (dev_start_i) dcnt <= 1;
            else if (dcnt != 0) dcnt <= (dcnt == 8) ? 0 : dcnt + 1;
        end
    end
    assign mem_done_o = mcnt > lat;
    assign io_done_o = dcnt > 6; // Completion pulse after the minimum time
    // Stale data is inverted so early sampling shows up
    assign mem_rdata_o = mem_done_o ? mem[addr_q] : ~mem[addr_q];
endmodule
`default_nettype wire

// ### verif/skip_operate_iot_console_control_test.sv
// Purpose: self-checking bench for the control block
// Assumes: program loaded through the deposit button
// Notes: test word kept positive so the sign tests are predictable
`default_nettype none
`include "cpu_ctl_map.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module skip_operate_iot_console_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [14:0] BASE = 15'h0040;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic arith_ovf_i = 1'b0;
    logic single_cyc_i = 1'b0;
    logic [14:0] test_addr_i = BASE;
    logic [35:0] test_word_i = '0;
    logic [5:0] sense_sw_i = '0;
    logic [5:0] flag_set_i = '0;
    logic [4:0] btn = '0; // Start, stop, continue, examine, deposit
    wire start_i = btn[0];
    wire stop_i = btn[1];
    wire cont_i = btn[2];
    wire examine_i = btn[3];
    wire deposit_i = btn[4];
    logic [35:0] mem_rdata_i, mem_wdata_o, ac_o, io_o, mb_o, tw, prog [0:17];
    logic mem_done_i, io_done_i, mem_rd_o, mem_wr_o, ovf_o, run_o, dev_start_o;
    logic [14:0] mem_addr_o, pc_o;
    logic [5:0] flags_o;
    logic [2:0] dev_func_o, seen_func = '0;
    logic [31:0] seed = 32'h0000_0062;
    logic [31:0] val;
    int fail_count = 0;
    int n_tests = 0;
    cpu_ctl u_dut (.*);
    mem_dev_model u_far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .dev_start_i(dev_start_o),
        .mem_rdata_o(mem_rdata_i), .mem_done_o(mem_done_i), .io_done_o(io_done_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Instruction word: opcode, gap, wait bit, address
    function automatic logic [35:0] w(input logic [5:0] op, input logic [11:0] a, input logic wt = 1'b0);
        return {op, 17'h0_0000, wt, a};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic press(input int b);
        btn[b] <= 1'b1;
        cyc(5);
        btn[b] <= 1'b0;
        cyc(40);
    endtask
    // Bounded wait for the machine to park
    task automatic wait_idle();
        int n;
        n = 0;
        while (run_o !== 1'b0 && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic pulse_ovf();
        arith_ovf_i <= 1'b1;
        cyc(2);
        arith_ovf_i <= 1'b0;
        cyc(6);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        if (dev_start_o === 1'b1) seen_func <= dev_func_o;
    end
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        cyc(20000);
        fail_count++;
        give_verdict();
    end
    initial begin
        prog = '{w(`OP_OPER, `OPR_LAT | `OPR_CLA), w(`OP_SKIP, `SK_PLUS_AC), w(`OP_OPER, `OPR_CMA),
            w(`OP_SKIP, `SK_MINUS_AC), w(`OP_OPER, `OPR_CMA), w(`OP_IOT, 12'h002, 1'b1),
            w(`OP_SKIP, `SK_ZERO_OV | `SK_PLUS_IO), w(`OP_OPER, `OPR_CMA), w(`OP_OPER, 12'h00F),
            w(`OP_SKIP, 12'h007), w(`OP_OPER, 12'h007), w(`OP_SKIP, 12'h007), w(`OP_OPER, `OPR_CMA),
            w(`OP_SKIP, 12'h038), w(`OP_OPER, `OPR_CLI | `OPR_HLT), w(`OP_SKIP, `SK_ZERO_OV),
            w(`OP_OPER, `OPR_CMA), w(`OP_OPER, `OPR_HLT)};
        cyc(20);
        rst_n_i <= 1'b1;
        cyc(2);
        for (int i = 0; i < 18; i++) begin
            test_addr_i <= BASE + 15'(i);
            test_word_i <= prog[i];
            press(4);
        end
        val = rnd();
        tw = {1'b0, val, 3'h5};
        test_word_i <= tw;
        sense_sw_i <= val[5:0] | 6'h01;
        test_addr_i <= BASE;
        pulse_ovf();
        `CHK("ovf set", 1'b1, ovf_o)
        press(0);
        wait_idle();
        `CHK("ac run1", ~tw, ac_o)
        `CHK("ovf start", 1'b0, ovf_o)
        `CHK("flags", 6'h00, flags_o)
        `CHK("io", 36'h0_0000_0000, io_o)
        `CHK("pc halt", BASE + 15'h000F, pc_o)
        `CHK("func", 3'h2, seen_func)
        pulse_ovf();
        press(2);
        wait_idle();
        `CHK("ac run2", tw, ac_o)
        `CHK("ovf szo", 1'b0, ovf_o)
        `CHK("pc cont", BASE + 15'h0012, pc_o)
        test_addr_i <= BASE + 15'h0001;
        press(3);
        `CHK("ac exam", prog[1], ac_o)
        `CHK("mb exam", prog[1], mb_o)
        single_cyc_i <= 1'b1;
        test_addr_i <= BASE + 15'h000F;
        press(0);
        `CHK("pc step1", BASE + 15'h0011, pc_o)
        `CHK("run step1", 1'b0, run_o)
        press(2);
        `CHK("pc step2", BASE + 15'h0012, pc_o)
        `CHK("ac step2", prog[1], ac_o)
        give_verdict();
    end
endmodule
`default_nettype wire
